// *** core/operand_alignment_check_defines.vh ***
// Constants for the operand alignment checker
`ifndef OPERAND_ALIGNMENT_CHECK_DEFINES_VH
`define OPERAND_ALIGNMENT_CHECK_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_STATUS     12'h000
`define OFF_ENABLE     12'h004
`define OFF_CLEAR      12'h008
`define OFF_LAST_EA    12'h00C
`define OFF_LAST_INSTR 12'h010
`define OFF_FAULT_CNT  12'h014

// ****************************************
// Status, enable and clear bit positions
// ****************************************
`define ST_ALIGN    0
`define ST_ILLEGAL  1
`define ST_RESERVED 2
`define ST_MISALIGN 3
`define ST_WIDTH    4

// ****************************************
// Reset values
// ****************************************
`define RST_ENABLE  4'h0
`define RST_STATUS  4'h0

// ****************************************
// Instruction classes
// ****************************************
`define CLS_DEFINED  2'h0
`define CLS_ILLEGAL  2'h1
`define CLS_RESERVED 2'h2

// ****************************************
// Operand sizes
// ****************************************
`define SZ_BYTE   2'h0
`define SZ_HALF   2'h1
`define SZ_WORD   2'h2
`define SZ_DOUBLE 2'h3

// ****************************************
// Memory operation kinds
// ****************************************
`define OPK_NONE  3'h0
`define OPK_LDST  3'h1
`define OPK_RESV  3'h2
`define OPK_DCBZ  3'h3
`define OPK_CACHE 3'h4

// ****************************************
// Opcode fields and timing
// ****************************************
`define PRIM_HI   31
`define PRIM_LO   26
`define XOP_HI    10
`define XOP_LO    1
`define CACHE_MASK_BITS 4
`define APB_WAIT_CYCLES 1

`endif

// *** core/opcode_class_decode.v ***
// Instruction class decoder for primary and extended opcodes
`timescale 1ns/100ps
`include "operand_alignment_check_defines.vh"

module opcode_class_decode (
  input  wire [31:0] instr,
  output reg  [1:0]  instr_class
);

  // ****************************************
  // Extended opcodes under primary 19
  // ****************************************
  function is_defined_19;
    input [9:0] xop;
    begin
      case (xop)
        10'd0, 10'd16, 10'd33, 10'd50, 10'd51, 10'd129, 10'd150,
        10'd193, 10'd225, 10'd257, 10'd289, 10'd417, 10'd449,
        10'd528: is_defined_19 = 1'b1;
        default: is_defined_19 = 1'b0;
      endcase
    end
  endfunction

  wire [5:0] prim;
  wire [9:0] xop;

  assign prim = instr[`PRIM_HI:`PRIM_LO];
  assign xop  = instr[`XOP_HI:`XOP_LO];

  // Class selection
  always @* begin
    if (instr == 32'h0000_0000) begin
      instr_class = `CLS_ILLEGAL; // [RULE11]
    end else if (prim == 6'd0) begin
      instr_class = `CLS_RESERVED; // [RULE11]
    end else if (prim == 6'd4) begin
      instr_class = `CLS_RESERVED;
    end else if (prim == 6'd1 || prim == 6'd5 || prim == 6'd6 ||
                 prim == 6'd56 || prim == 6'd57 || prim == 6'd60 ||
                 prim == 6'd61 || prim == 6'd58 || prim == 6'd62) begin
      instr_class = `CLS_ILLEGAL; // [RULE12]
    end else if (prim >= 6'd48 && prim <= 6'd55) begin
      instr_class = `CLS_ILLEGAL;
    end else if (prim == 6'd59 || prim == 6'd63) begin
      instr_class = `CLS_ILLEGAL;
    end else if (prim == 6'd19 && !is_defined_19(xop)) begin
      instr_class = `CLS_ILLEGAL; // [RULE12]
    end else begin
      instr_class = `CLS_DEFINED;
    end
  end

endmodule

// *** core/operand_alignment_check.v ***
// Operand alignment checker with APB status and interrupt registers
`timescale 1ns/100ps
`include "operand_alignment_check_defines.vh"

// Overview of operation
// [RULE1] Alignment judged from low four address bits
// [RULE2] Aligned only at multiples of operand length
// [RULE3] Instruction fetch addresses forced to words
// [RULE4] Endian attribute ignored by alignment check
// [RULE5] Little-endian adds no extra alignment faults
// [RULE6] Ordinary misaligned loads/stores complete, no fault
// [RULE7] Reservation and cache-read need word alignment
// [RULE8] Zeroing uncached/write-through, translation off faults
// [RULE9] Cache ops drop four low address bits
// [RULE10] Cache ops never fault on address value
// [RULE11] Decoder sorts into defined, illegal, reserved
// [RULE12] Unknown opcode combinations are illegal; code decodes every primary 31 extended opcode as defined
// [RULE13] Undefined outcomes limited to reachable states
// [RULE14] Faulting instruction commits nothing
module operand_alignment_check #(
  parameter ADDR_W = 12,
  parameter CNT_W  = 16
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              req_valid,
  input  wire [31:0]       req_instr,
  input  wire [31:0]       effective_address,
  input  wire              data_translation_enable,
  input  wire              region_cacheable,
  input  wire              region_write_through,
  input  wire              region_little_endian,
  input  wire [31:0]       fetch_address,
  output reg               rsp_valid,
  output reg               rsp_align_exc,
  output reg               rsp_program_exc,
  output reg               rsp_misaligned,
  output reg               rsp_extra_cycle,
  output reg               rsp_commit,
  output reg  [1:0]        rsp_class,
  output reg  [31:0]       rsp_target_address,
  output reg               rsp_little_endian,
  output reg  [31:0]       fetch_word_address,
  output reg               irq
);

  // ****************************************
  // Functions
  // ****************************************
  function is_misaligned;
    input [1:0] size;
    input [3:0] low;
    begin
      case (size)
        `SZ_BYTE:  is_misaligned = 1'b0;        // [RULE1]
        `SZ_HALF:  is_misaligned = low[0];      // [RULE1]
        `SZ_WORD:  is_misaligned = |low[1:0];   // [RULE1]
        default:   is_misaligned = |low[2:0];   // [RULE2]
      endcase
    end
  endfunction

  function crosses_word;
    input [1:0] size;
    input [3:0] low;
    begin
      case (size)
        `SZ_BYTE:  crosses_word = 1'b0;
        `SZ_HALF:  crosses_word = (low[1:0] == 2'h3);
        `SZ_WORD:  crosses_word = |low[1:0];
        default:   crosses_word = 1'b1;
      endcase
    end
  endfunction

  function [31:0] cache_line_base;
    input [31:0] ea;
    begin
      cache_line_base = {ea[31:`CACHE_MASK_BITS], {`CACHE_MASK_BITS{1'b0}}};
    end
  endfunction

  function is_read_only;
    input [ADDR_W-1:0] addr;
    begin
      is_read_only = (addr == `OFF_STATUS) ||
                     (addr == `OFF_LAST_EA) ||
                     (addr == `OFF_LAST_INSTR) ||
                     (addr == `OFF_FAULT_CNT);
    end
  endfunction

  function [4:0] mem_op;
    input [31:0] ins;
    reg   [5:0]  p;
    reg   [9:0]  x;
    begin
      p = ins[`PRIM_HI:`PRIM_LO];
      x = ins[`XOP_HI:`XOP_LO];
      mem_op = {`OPK_NONE, `SZ_BYTE};
      case (p)
        6'd32, 6'd33, 6'd36, 6'd37, 6'd46, 6'd47:
          mem_op = {`OPK_LDST, `SZ_WORD};
        6'd34, 6'd35, 6'd38, 6'd39:
          mem_op = {`OPK_LDST, `SZ_BYTE};
        6'd40, 6'd41, 6'd42, 6'd43, 6'd44, 6'd45:
          mem_op = {`OPK_LDST, `SZ_HALF};
        6'd31: begin
          case (x)
            10'd20, 10'd150, 10'd486:
              mem_op = {`OPK_RESV, `SZ_WORD};
            10'd1014:
              mem_op = {`OPK_DCBZ, `SZ_BYTE};
            10'd54, 10'd86, 10'd246, 10'd278, 10'd470, 10'd758,
            10'd454, 10'd262, 10'd982, 10'd966, 10'd998:
              mem_op = {`OPK_CACHE, `SZ_BYTE};
            10'd23, 10'd55, 10'd151, 10'd183, 10'd534, 10'd662:
              mem_op = {`OPK_LDST, `SZ_WORD};
            10'd87, 10'd119, 10'd215, 10'd247:
              mem_op = {`OPK_LDST, `SZ_BYTE};
            10'd279, 10'd311, 10'd343, 10'd375, 10'd407, 10'd439,
            10'd790, 10'd918:
              mem_op = {`OPK_LDST, `SZ_HALF};
            default:
              mem_op = {`OPK_NONE, `SZ_BYTE};
          endcase
        end
        default: mem_op = {`OPK_NONE, `SZ_BYTE};
      endcase
    end
  endfunction

  // ****************************************
  // Decode of the current request
  // ****************************************
  wire [1:0]  cls;
  wire [4:0]  op;
  wire [2:0]  kind;
  wire [1:0]  size;
  wire [3:0]  low;
  reg         align_fault;
  reg         misal;
  reg         extra;
  reg         prog_fault;
  reg  [31:0] target;

  opcode_class_decode u_class (
    .instr       (req_instr),
    .instr_class (cls)
  );

  assign op   = mem_op(req_instr);
  assign kind = op[4:2];
  assign size = op[1:0];
  assign low  = effective_address[3:0];

  // Endian attribute deliberately left out of every term below
  always @* begin
    align_fault = 1'b0;                            // [RULE4]
    misal       = 1'b0;
    extra       = 1'b0;
    target      = effective_address;
    prog_fault  = (cls == `CLS_ILLEGAL) ||
                  (cls == `CLS_RESERVED &&
                   req_instr[`PRIM_HI:`PRIM_LO] == 6'd0); // [RULE13]
    if (cls == `CLS_DEFINED) begin
      case (kind)
        `OPK_LDST: begin
          misal = is_misaligned(size, low);        // [RULE2]
          extra = crosses_word(size, low);         // [RULE6]
        end
        `OPK_RESV: begin
          misal       = is_misaligned(size, low);
          align_fault = misal;                     // [RULE7]
        end
        `OPK_DCBZ: begin
          target      = cache_line_base(effective_address); // [RULE9]
          align_fault = !data_translation_enable &&
                        (!region_cacheable ||
                         region_write_through);    // [RULE8]
        end
        `OPK_CACHE: begin
          target      = cache_line_base(effective_address); // [RULE9]
          align_fault = 1'b0;                      // [RULE10]
        end
        default: begin
          misal = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Response registers
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid          <= 1'b0;
      rsp_align_exc      <= 1'b0;
      rsp_program_exc    <= 1'b0;
      rsp_misaligned     <= 1'b0;
      rsp_extra_cycle    <= 1'b0;
      rsp_commit         <= 1'b0;
      rsp_class          <= `CLS_DEFINED;
      rsp_target_address <= 32'h0000_0000;
      rsp_little_endian  <= 1'b0;
      fetch_word_address <= 32'h0000_0000;
    end else begin
      rsp_valid          <= req_valid;
      rsp_align_exc      <= req_valid && align_fault;  // [RULE5]
      rsp_program_exc    <= req_valid && prog_fault;
      rsp_misaligned     <= req_valid && misal;
      rsp_extra_cycle    <= req_valid && extra;        // [RULE6]
      rsp_commit         <= req_valid && !align_fault &&
                            !prog_fault;               // [RULE14]
      rsp_class          <= cls;                       // [RULE11]
      rsp_target_address <= target;
      rsp_little_endian  <= region_little_endian;      // [RULE4]
      fetch_word_address <= {fetch_address[31:2], 2'b00}; // [RULE3]
    end
  end

  // ****************************************
  // Event capture
  // ****************************************
  reg  [`ST_WIDTH-1:0] status_r;
  reg  [`ST_WIDTH-1:0] status_nxt;
  reg  [`ST_WIDTH-1:0] enable_r;
  reg  [`ST_WIDTH-1:0] enable_nxt;
  reg  [31:0]          last_ea_r;
  reg  [31:0]          last_instr_r;
  reg  [CNT_W-1:0]     fault_cnt_r;
  wire [`ST_WIDTH-1:0] events;
  wire [`ST_WIDTH-1:0] clear_bits;
  wire                 wr_access;
  wire                 any_fault;

  assign events[`ST_ALIGN]    = req_valid && align_fault;
  assign events[`ST_ILLEGAL]  = req_valid && cls == `CLS_ILLEGAL;
  assign events[`ST_RESERVED] = req_valid && cls == `CLS_RESERVED;
  assign events[`ST_MISALIGN] = req_valid && misal && !align_fault;
  assign any_fault = req_valid && (align_fault || prog_fault);

  assign wr_access  = psel && penable && pready && pwrite;
  assign clear_bits = (wr_access && paddr == `OFF_CLEAR) ?
                      pwdata[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};

  // A set in the same cycle as its clear survives
  always @* begin
    status_nxt = (status_r & ~clear_bits) | events;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r     <= `RST_STATUS;
      last_ea_r    <= 32'h0000_0000;
      last_instr_r <= 32'h0000_0000;
      fault_cnt_r  <= {CNT_W{1'b0}};
    end else begin
      status_r <= status_nxt;
      if (any_fault) begin
        last_ea_r    <= effective_address;
        last_instr_r <= req_instr;
        if (fault_cnt_r != {CNT_W{1'b1}}) begin
          fault_cnt_r <= fault_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // ****************************************
  // Interrupt output
  // ****************************************
  // Enable write seen by irq on the same edge
  always @* begin
    enable_nxt = enable_r;
    if (wr_access && paddr == `OFF_ENABLE) begin
      enable_nxt = pwdata[`ST_WIDTH-1:0];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_nxt & enable_nxt);
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  reg  [31:0] rd_word;
  reg         rd_err;

  always @* begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    if (paddr == `OFF_STATUS) begin
      rd_word = {{(32-`ST_WIDTH){1'b0}}, status_r};
    end else if (paddr == `OFF_ENABLE) begin
      rd_word = {{(32-`ST_WIDTH){1'b0}}, enable_r};
    end else if (paddr == `OFF_CLEAR) begin
      rd_word = 32'h0000_0000;
    end else if (paddr == `OFF_LAST_EA) begin
      rd_word = last_ea_r;
    end else if (paddr == `OFF_LAST_INSTR) begin
      rd_word = last_instr_r;
    end else if (paddr == `OFF_FAULT_CNT) begin
      rd_word = {{(32-CNT_W){1'b0}}, fault_cnt_r};
    end else begin
      rd_err = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      enable_r <= `RST_ENABLE;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= rd_err ||
                   (pwrite && is_read_only(paddr));
      end else begin
        pslverr <= 1'b0;
      end
      enable_r <= enable_nxt;
    end
  end

endmodule

// *** verification/operand_alignment_check_checker.sv ***
// Port-level assertions for the operand alignment checker
`timescale 1ns/100ps
`include "operand_alignment_check_defines.vh"
module operand_alignment_check_checker (
  input logic        clk,
  input logic        rst_n,
  input logic        psel,
  input logic        penable,
  input logic        pready,
  input logic        req_valid,
  input logic [31:0] req_instr,
  input logic [31:0] effective_address,
  input logic        data_translation_enable,
  input logic        region_cacheable,
  input logic        region_write_through,
  input logic [31:0] fetch_address,
  input logic        rsp_valid,
  input logic        rsp_align_exc,
  input logic        rsp_program_exc,
  input logic        rsp_misaligned,
  input logic        rsp_commit,
  input logic [1:0]  rsp_class,
  input logic [31:0] rsp_target_address,
  input logic [31:0] fetch_word_address
);
  // ****************************************
  // Request decode
  // ****************************************
  wire [5:0] op       = req_instr[31:26];
  wire [9:0] xo       = req_instr[10:1];
  wire       x31      = req_valid && op == 6'h1F;
  wire       rsv_op   = x31 && (xo == 10'h014 || xo == 10'h096 || xo == 10'h1E6);
  wire       zero_op  = x31 && xo == 10'h3F6;
  wire       cache_op = x31 && xo == 10'h056;
  wire       zero_bad = !data_translation_enable && (!region_cacheable || region_write_through);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Assertions
  // ****************************************
  a_rsp_follows: assert property (req_valid |=> rsp_valid)
    else $error("response missing");
  a_commit_clean: assert property (
    rsp_commit |-> rsp_valid && !rsp_align_exc && !rsp_program_exc) else $error("bad commit");
  a_resv_align: assert property (
    rsv_op |=> rsp_align_exc == (($past(effective_address) & 32'h3) != 32'h0))
    else $error("reservation alignment");
  a_zero_fault: assert property (zero_op |=> rsp_align_exc == $past(zero_bad))
    else $error("zeroing fault");
  a_cache_mask: assert property (
    cache_op |=> rsp_target_address == ($past(effective_address) & 32'hFFFFFFF0))
    else $error("cache address mask");
  a_cache_nofault: assert property (cache_op |=> !rsp_align_exc)
    else $error("cache op faulted");
  a_word_misalign: assert property (req_valid && op == 6'h20 |=> !rsp_align_exc &&
    rsp_misaligned == (($past(effective_address) & 32'h3) != 32'h0)) else $error("word load");
  a_half_misalign: assert property (req_valid && op == 6'h28 |=>
    rsp_misaligned == (($past(effective_address) & 32'h1) != 32'h0)) else $error("half load");
  a_zero_illegal: assert property (req_valid && req_instr == 32'h0 |=>
    rsp_class == `CLS_ILLEGAL && rsp_program_exc) else $error("zero word class");
  a_fetch_word: assert property ($past(rst_n) |->
    fetch_word_address == ($past(fetch_address) & 32'hFFFFFFFC)) else $error("fetch align");
  a_pready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready timing");
endmodule

// *** verification/tb_operand_alignment_check.sv ***
// Self-checking testbench for the operand alignment checker
`timescale 1ns/100ps
`include "operand_alignment_check_defines.vh"
module tb_operand_alignment_check;
  logic        clk, rst_n, psel, penable, pwrite, req_valid, dte, cach, wt, le, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, req_instr, effective_address, fetch_address, rdat;
  int          num_errors, checks_done, cyc;
  wire  [31:0] prdata, rsp_target_address, fetch_word_address;
  wire  [1:0]  rsp_class;
  wire         pready, pslverr, rsp_valid, rsp_align_exc, rsp_program_exc, rsp_misaligned;
  wire         rsp_extra_cycle, rsp_commit, rsp_little_endian, irq;

  operand_alignment_check dut (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .req_valid, .req_instr, .effective_address, .data_translation_enable(dte),
    .region_cacheable(cach), .region_write_through(wt), .region_little_endian(le),
    .fetch_address, .rsp_valid, .rsp_align_exc, .rsp_program_exc, .rsp_misaligned,
    .rsp_extra_cycle, .rsp_commit, .rsp_class, .rsp_target_address, .rsp_little_endian,
    .fetch_word_address, .irq
  );

  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim;
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_sim;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask

  function automatic logic [31:0] mk(input int p, input int x);
    mk = {p[5:0], 15'h0, x[9:0], 1'b0};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rq(input logic [31:0] i, input logic [31:0] adr, input logic [3:0] at);
    @(posedge clk);
    req_valid <= 1;
    req_instr <= i;
    effective_address <= adr;
    {dte, cach, wt, le} <= at;
    @(posedge clk);
    req_valid <= 0;
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    apb(0, `OFF_ENABLE, 0);
    chk(rdat, `RST_ENABLE);
    apb(0, `OFF_STATUS, 0);
    chk(rdat, `RST_STATUS);
    apb(0, 12'h03C, 0);
    chk({rerr, rdat[30:0]}, 32'h80000000);
    apb(1, `OFF_STATUS, 32'hF);
    chk(rerr, 1);
    @(posedge clk);
    fetch_address <= 32'h87654323;
    @(posedge clk);
    #1;
    chk(fetch_word_address, 32'h87654320);
  endtask

  task automatic t_ldst;
    int op[3] = '{34, 40, 32};
    for (int e = 0; e < 2; e++)
      for (int s = 0; s < 3; s++)
        for (int a = 0; a < 4; a++) begin
          rq(mk(op[s], 0), 32'h100 + a, 4'hC + e[3:0]);
          chk(rsp_misaligned, (a & ((1 << s) - 1)) != 0);
          chk({rsp_align_exc, rsp_commit}, 2'h1);
          chk(rsp_extra_cycle, a + (1 << s) > 4);
          chk(rsp_little_endian, e[0]);
        end
  endtask

  task automatic t_resv;
    int xo[3] = '{20, 150, 486};
    for (int e = 0; e < 2; e++)
      for (int k = 0; k < 3; k++)
        for (int a = 0; a < 4; a++) begin
          rq(mk(31, xo[k]), 32'h200 + a, 4'hC + e[3:0]);
          chk(rsp_align_exc, a != 0);
          chk(rsp_commit, a == 0);
        end
  endtask

  task automatic t_cache;
    int xo[11] = '{54, 86, 246, 278, 470, 758, 454, 262, 982, 966, 998};
    for (int c = 0; c < 8; c++) begin
      rq(mk(31, 1014), 32'h1234567F, {c[2:0], ^c[2:0]});
      chk(rsp_align_exc, !c[2] && (!c[1] || c[0]));
      chk(rsp_commit, c[2] || (c[1] && !c[0]));
      chk(rsp_target_address, 32'h12345670);
    end
    for (int k = 0; k < 11; k++) begin
      rq(mk(31, xo[k]), 32'hABCDEF0B, 4'h0);
      chk(rsp_align_exc, 0);
      chk(rsp_target_address, 32'hABCDEF00);
    end
  endtask

  task automatic t_class;
    logic [31:0] ins[8] = '{32'h0, 32'h100, mk(4, 8), mk(1, 0), mk(19, 16), mk(19, 3),
                            mk(14, 0), mk(63, 0)};
    logic [2:0]  ex[8] = '{3'h3, 3'h5, 3'h4, 3'h3, 3'h0, 3'h3, 3'h0, 3'h3};
    for (int k = 0; k < 8; k++) begin
      rq(ins[k], 32'h0, 4'hC);
      chk(rsp_class, ex[k][2:1]);
      chk(rsp_program_exc, ex[k][0]);
      chk(rsp_commit, !ex[k][0]);
    end
  endtask

  task automatic t_irq;
    apb(1, `OFF_CLEAR, 32'hF);
    apb(1, `OFF_ENABLE, 32'h1);
    rq(mk(31, 20), 32'h302, 4'hC);
    chk(irq, 1);
    apb(0, `OFF_LAST_EA, 0);
    chk(rdat, 32'h302);
    apb(0, `OFF_LAST_INSTR, 0);
    chk(rdat, mk(31, 20));
    apb(1, `OFF_CLEAR, 32'h1);
    apb(0, `OFF_STATUS, 0);
    chk({irq, rdat[0]}, 2'h0);
    apb(1, `OFF_ENABLE, 32'h2);
    rq(mk(31, 150), 32'h303, 4'hC);
    chk(irq, 0);
    rq(32'h0, 32'h0, 4'hC);
    chk(irq, 1);
    apb(0, `OFF_STATUS, 0);
    chk(rdat[3:0], 4'h3);
    apb(0, `OFF_FAULT_CNT, 0);
    chk(rdat, 32'h0000_001D);
    apb(1, `OFF_CLEAR, 32'hF);
    @(posedge clk);
    #1;
    chk(irq, 0);
  endtask

  initial begin
    {psel, penable, pwrite, req_valid, dte, cach, wt, le} = 8'h0;
    paddr = 0;
    pwdata = 0;
    req_instr = 0;
    effective_address = 0;
    fetch_address = 0;
    rst_n = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    t_regs;
    t_ldst;
    t_resv;
    t_cache;
    t_class;
    t_irq;
    end_sim;
  end
endmodule

bind operand_alignment_check operand_alignment_check_checker chk_i (
  .clk, .rst_n, .psel, .penable, .pready, .req_valid, .req_instr, .effective_address,
  .data_translation_enable, .region_cacheable, .region_write_through, .fetch_address,
  .rsp_valid, .rsp_align_exc, .rsp_program_exc, .rsp_misaligned, .rsp_commit, .rsp_class,
  .rsp_target_address, .fetch_word_address
);
